// ---- bench/tsf_filter_bench.sv ----
// Self-checking bench for the touch second/third level filter top.
module tsf_filter_bench;
	timeunit 1ns;
	timeprecision 100ps;
	import tsf_pkg::*;

	typedef struct packed {
		logic w;
		logic [7:0] a;
		logic [7:0] d;
		logic [7:0] e;
	} tsf_row_t;

	// Short millisecond keeps the longest interval test brief
	localparam int MS = 10;
	logic clk_sys, reset, l1_valid, touch_in, filt_valid;
	logic baseline_valid, touch_active;
	tsf_reg_req_t reg_req;
	tsf_thr_t thr;
	logic [7:0] reg_rdata, rd;
	logic [9:0] l1_data, filt_data, baseline_data;
	logic [2:0] charge_time_sel;
	logic [11:0] charge_cycles;
	int num_errors, total_checks, n;
	int nsamp [4] = '{4, 6, 10, 18};
	// Reset values first, then write/readback, barred and unmapped cases
	tsf_row_t rows [14] = '{
		'{1'b0, 8'h43, 8'h00, 8'h24}, '{1'b0, 8'h26, 8'h00, 8'h01},
		'{1'b0, 8'h27, 8'h00, 8'h01}, '{1'b0, 8'h28, 8'h00, 8'h00},
		'{1'b0, 8'h04, 8'h00, 8'h00}, '{1'b0, 8'h05, 8'h00, 8'h00},
		'{1'b1, 8'h26, 8'h3F, 8'h3F}, '{1'b1, 8'h27, 8'h05, 8'h05},
		'{1'b1, 8'h28, 8'h0F, 8'h0F}, '{1'b1, 8'h43, 8'h3F, 8'h3F},
		'{1'b1, 8'h30, 8'hAA, 8'h00}, '{1'b1, 8'h26, 8'h00, 8'h3F},
		'{1'b1, 8'h27, 8'h00, 8'h05}, '{1'b1, 8'h43, 8'h1B, 8'h3B}};

	tsf_filter #(.MS_CYCLES_P(MS)) dut (
		.clk_sys(clk_sys),
		.reset(reset),
		.reg_req(reg_req),
		.reg_rdata(reg_rdata),
		.l1_valid(l1_valid),
		.l1_data(l1_data),
		.touch_in(touch_in),
		.thr(thr),
		.charge_time_sel(charge_time_sel),
		.charge_cycles(charge_cycles),
		.filt_valid(filt_valid),
		.filt_data(filt_data),
		.baseline_valid(baseline_valid),
		.baseline_data(baseline_data),
		.touch_active(touch_active)
	);

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Inputs always move 1 ns after the rising edge
	task cyc(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask : cyc

	task wr(input logic [7:0] a, input logic [7:0] d);
		reg_req.wr = 1'b1;
		reg_req.addr = a;
		reg_req.wdata = d;
		cyc(1);
		reg_req.wr = 1'b0;
		cyc(1);
	endtask : wr

	task rdr(input logic [7:0] a, output logic [7:0] d);
		reg_req.rd = 1'b1;
		reg_req.addr = a;
		cyc(1);
		reg_req.rd = 1'b0;
		d = reg_rdata;
		cyc(1);
	endtask : rdr

	// Bounded wait; n holds the cycles taken
	task wait_fv();
		n = 0;
		do begin
			cyc(1);
			n++;
		end while (filt_valid !== 1'b1 && n < 6000);
		if (n >= 6000) check(16'h0000, 16'h0001); // no average
	endtask : wait_fv

	// One clean average of v, then look at baseline and touch state
	task step(input logic [9:0] v, input logic [9:0] eb, input logic et);
		l1_data = v;
		wait_fv();
		cyc(1);
		check(16'(baseline_data), 16'(eb)); // baseline
		check(16'(touch_active), 16'(et)); // touch state
	endtask : step

	task report_and_stop();
		$display("Checks %0d, errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : report_and_stop

	// Watchdog well beyond the expected run length
	initial begin
		#1_000_000;
		num_errors++;
		report_and_stop();
	end

	initial begin
		reset = 1'b1;
		reg_req = '0;
		l1_valid = 1'b1;
		l1_data = 10'h200;
		touch_in = 1'b0;
		thr = '0;
		cyc(8);
		reset = 1'b0;
		check(16'(charge_cycles), 16'h0032); // reset decode
		foreach (rows[i]) begin
			if (rows[i].w)
				wr(rows[i].a, rows[i].d);
			rdr(rows[i].a, rd);
			check(16'(rd), 16'(rows[i].e));
		end
		for (int c = 1; c < 8; c++) begin
			wr(8'h43, {3'(c), 5'h00});
			check(16'(charge_time_sel), 16'(c)); // code out
			check(16'(charge_cycles), 16'(12'h032 << (c - 1)));
		end
		for (int e = 0; e < 8; e++) begin
			wr(8'h43, {3'h1, 2'h0, 3'(e)});
			wait_fv();
			wait_fv();
			wait_fv();
			check(16'(n), 16'(4 * MS << e));
		end
		// sample count codes at 1 ms
		for (int s = 0; s < 4; s++) begin
			wr(8'h43, {3'h1, 2'(s), 3'h0});
			wait_fv();
			wait_fv();
			wait_fv();
			check(16'(n), 16'(MS * nsamp[s]));
		end
		// Drift tracking: max step 2, drift step 3, run of two
		wr(8'h43, 8'h20);
		wr(8'h26, 8'h02);
		wr(8'h27, 8'h03);
		wr(8'h28, 8'h01);
		wait_fv();
		cyc(1);
		check(16'(baseline_valid), 16'h0001); // baseline loaded
		step(10'h20A, 10'h200, 1'b0); // first excursion
		step(10'h20A, 10'h203, 1'b0); // step
		step(10'h20A, 10'h203, 1'b0); // run restarts
		step(10'h20A, 10'h206, 1'b0);
		wr(8'h28, 8'h00);
		wait_fv();
		cyc(1);
		check(16'(baseline_data), 16'h0209); // code zero every time
		step(10'h20A, 10'h20A, 1'b0); // within max step, baseline takes input
		step(10'h208, 10'h208, 1'b0); // within max step
		// Touch hold, release, external flag, then detection off
		wr(8'h26, 8'h3F);
		thr = {8'h05, 8'h03};
		wait_fv();
		cyc(1);
		step(10'h1FE, 10'h208, 1'b1); // touch freezes
		step(10'h1FE, 10'h208, 1'b1); // still held
		step(10'h208, 10'h208, 1'b0); // released
		touch_in = 1'b1;
		step(10'h212, 10'h208, 1'b0); // external flag holds
		thr = '0;
		step(10'h1F4, 10'h1F4, 1'b0); // plain low-pass
		touch_in = 1'b0;
		// Floor of a six-sample mean and the data byte pair
		wr(8'h43, 8'h28);
		wait_fv();
		wait_fv();
		for (int m = 0; m < 6; m++) begin
			l1_data = 10'h258 + 10'(m);
			if (m < 5)
				cyc(MS);
		end
		wait_fv();
		check(16'(filt_data), 16'h025A); // floor of mean
		rdr(8'h04, rd);
		check(16'(rd), 16'h005A); // low byte
		rdr(8'h05, rd);
		check(16'(rd), 16'h0002); // high bits
		// No first-stage results: at most one held take, no average
		l1_valid = 1'b0;
		n = 0;
		repeat (200) begin
			cyc(1);
			if (filt_valid === 1'b1)
				n++;
		end
		check(16'(n), 16'h0000); // no average emitted
		// Mid-run reset clears registers, average and baseline
		reset = 1'b1;
		cyc(2);
		reset = 1'b0;
		check(16'(reg_rdata), 16'h0000); // read data cleared
		check(16'(filt_data), 16'h0000); // average cleared
		check(16'(baseline_valid), 16'h0000); // baseline cleared
		check(16'(charge_time_sel), 16'h0001); // reset code
		rdr(8'h43, rd);
		check(16'(rd), 16'h0024); // reset config
		l1_valid = 1'b1;
		wait_fv();
		cyc(1);
		check(16'(baseline_data), 16'(l1_data)); // first average loads
		report_and_stop();
	end
endmodule : tsf_filter_bench

// ---- design/tsf_avg.sv ----
// Second-stage averager: sums N taken samples and emits their mean.
module tsf_avg import tsf_pkg::*; (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic take,
	input wire logic [TSF_DATA_W-1:0] din,
	input wire logic [1:0] sel,
	output logic dout_valid,
	output logic [TSF_DATA_W-1:0] dout
);
	logic [4:0] cnt_r, cnt_nxt;
	logic [TSF_SUM_W-1:0] sum_r, sum_nxt;
	logic [TSF_DATA_W-1:0] dout_r, dout_nxt;
	logic dv_r, dv_nxt;

	// Accumulate; a shrinking count mid-run just ends the run early
	always_comb begin
		logic [TSF_SUM_W-1:0] s;
		s = sum_r + TSF_SUM_W'(din);
		cnt_nxt = cnt_r;
		sum_nxt = sum_r;
		dout_nxt = dout_r;
		dv_nxt = 1'b0;
		if (take) begin
			if (cnt_r + 5'd1 >= tsf_sample_n(sel)) begin
				dout_nxt = tsf_avg_div(s, sel);
				dv_nxt = 1'b1;
				cnt_nxt = 5'd0;
				sum_nxt = '0;
			end else begin
				cnt_nxt = cnt_r + 5'd1;
				sum_nxt = s;
			end
		end
	end

	// Averager state
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cnt_r <= 5'd0;
			sum_r <= '0;
			dout_r <= '0;
			dv_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			sum_r <= sum_nxt;
			dout_r <= dout_nxt;
			dv_r <= dv_nxt;
		end
	end

	assign dout_valid = dv_r;
	assign dout = dout_r;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	// A shrunk count may leave cnt_r high; the next take must still emit
	a_count_bound: assert property (take &&
		cnt_r + 5'd1 >= tsf_sample_n(sel) |=> cnt_r == 5'd0 && dv_r)
		else $error("average not emitted at sample total");
	a_emit_cause: assert property (dv_r |-> $past(take))
		else $error("average emitted without a taken sample");
	c_emit: cover property (dv_r && sel == 2'd3);
endmodule : tsf_avg

// ---- design/tsf_filter.sv ----
// Touch filter top: registers, interval timing, baseline and touch tracking.
module tsf_filter import tsf_pkg::*; #(
	parameter int MS_CYCLES_P = TSF_MS_CYCLES
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire tsf_reg_req_t reg_req,
	output logic [7:0] reg_rdata,
	input wire logic l1_valid,
	input wire logic [TSF_DATA_W-1:0] l1_data,
	input wire logic touch_in,
	input wire tsf_thr_t thr,
	output logic [2:0] charge_time_sel,
	output logic [11:0] charge_cycles,
	output logic filt_valid,
	output logic [TSF_DATA_W-1:0] filt_data,
	output logic baseline_valid,
	output logic [TSF_DATA_W-1:0] baseline_data,
	output logic touch_active
);
	tsf_cfg_t cfg_r, cfg_nxt;
	logic [5:0] max_step_r, max_step_nxt;
	logic [5:0] drift_step_r, drift_step_nxt;
	logic [3:0] drift_count_r, drift_count_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic [31:0] ms_cnt_r, ms_cnt_nxt;
	logic [7:0] ivl_cnt_r, ivl_cnt_nxt;
	logic [TSF_DATA_W-1:0] hold_r, hold_nxt;
	logic have_r, have_nxt;
	logic take;
	logic avg_v;
	logic [TSF_DATA_W-1:0] avg_d;
	logic [TSF_DATA_W-1:0] base_r, base_nxt;
	logic base_ok_r, base_ok_nxt;
	logic [3:0] run_r, run_nxt;
	logic dir_r, dir_nxt;
	logic touched_r, touched_nxt;
	logic det_en;
	tsf_cfg_t wcfg;

	assign wcfg = tsf_cfg_t'(reg_req.wdata);
	// detection on only when some threshold is set
	assign det_en = (thr.touch_th != 8'h00) || (thr.release_th != 8'h00);

	// Register writes and registered reads
	always_comb begin
		cfg_nxt = cfg_r;
		max_step_nxt = max_step_r;
		drift_step_nxt = drift_step_r;
		drift_count_nxt = drift_count_r;
		rdata_nxt = rdata_r;
		if (reg_req.wr) begin
			unique case (reg_req.addr)
				TSF_ADDR_FILTER_CFG: begin
					cfg_nxt = wcfg;
					// barred zero code keeps old time
					if (wcfg.charge_time_sel == 3'd0) begin
						cfg_nxt.charge_time_sel = cfg_r.charge_time_sel;
					end
				end
				TSF_ADDR_MAX_STEP: begin
					if (reg_req.wdata[5:0] != 6'h00) begin
						max_step_nxt = reg_req.wdata[5:0];
					end
				end
				TSF_ADDR_DRIFT_STEP: begin
					if (reg_req.wdata[5:0] != 6'h00) begin
						drift_step_nxt = reg_req.wdata[5:0];
					end
				end
				TSF_ADDR_DRIFT_COUNT: drift_count_nxt = reg_req.wdata[3:0];
				default: ;
			endcase
		end
		if (reg_req.rd) begin
			unique case (reg_req.addr)
				TSF_ADDR_FILTER_CFG: rdata_nxt = cfg_r;
				TSF_ADDR_MAX_STEP: rdata_nxt = {2'b00, max_step_r};
				TSF_ADDR_DRIFT_STEP: rdata_nxt = {2'b00, drift_step_r};
				TSF_ADDR_DRIFT_COUNT: rdata_nxt = {4'h0, drift_count_r};
				TSF_ADDR_FDATA_LO: rdata_nxt = avg_d[7:0];
				TSF_ADDR_FDATA_HI: rdata_nxt = {6'h00, avg_d[9:8]};
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	// Register file state
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			cfg_r <= tsf_cfg_t'(TSF_CFG_RST);
			max_step_r <= TSF_MAX_STEP_RST;
			drift_step_r <= TSF_DRIFT_STEP_RST;
			drift_count_r <= TSF_DRIFT_COUNT_RST;
			rdata_r <= 8'h00;
		end else begin
			cfg_r <= cfg_nxt;
			max_step_r <= max_step_nxt;
			drift_step_r <= drift_step_nxt;
			drift_count_r <= drift_count_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// Millisecond divider and interval timer; newest sample wins
	always_comb begin
		ms_cnt_nxt = ms_cnt_r + 32'd1;
		ivl_cnt_nxt = ivl_cnt_r;
		hold_nxt = hold_r;
		have_nxt = have_r;
		take = 1'b0;
		if (l1_valid) begin
			hold_nxt = l1_data;
			have_nxt = 1'b1;
		end
		if (ms_cnt_r >= 32'(MS_CYCLES_P - 1)) begin
			ms_cnt_nxt = 32'd0;
			ivl_cnt_nxt = ivl_cnt_r + 8'd1;
			if (ivl_cnt_r + 8'd1 >=
				tsf_interval_ms(cfg_r.sample_interval_sel)) begin
				ivl_cnt_nxt = 8'd0;
				take = have_r;
				if (!l1_valid) begin
					have_nxt = 1'b0;
				end
			end
		end
	end

	// Timing state
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ms_cnt_r <= 32'd0;
			ivl_cnt_r <= 8'd0;
			hold_r <= '0;
			have_r <= 1'b0;
		end else begin
			ms_cnt_r <= ms_cnt_nxt;
			ivl_cnt_r <= ivl_cnt_nxt;
			hold_r <= hold_nxt;
			have_r <= have_nxt;
		end
	end

	tsf_avg u_avg (
		.clk_sys(clk_sys),
		.reset(reset),
		.take(take),
		.din(hold_r),
		.sel(cfg_r.second_stage_sample_count),
		.dout_valid(avg_v),
		.dout(avg_d)
	);

	// Touch tracking and baseline update on each new average
	always_comb begin
		logic [TSF_DATA_W-1:0] mag;
		logic [TSF_DATA_W-1:0] fall;
		logic [3:0] run;
		logic up;
		up = avg_d > base_r;
		mag = up ? avg_d - base_r : base_r - avg_d;
		fall = (base_r > avg_d) ? base_r - avg_d : '0;
		run = 4'd1;
		touched_nxt = touched_r;
		base_nxt = base_r;
		base_ok_nxt = base_ok_r;
		run_nxt = run_r;
		dir_nxt = dir_r;
		if (!det_en) begin
			touched_nxt = 1'b0;
		end else if (avg_v && base_ok_r) begin
			// touch on large fall, release below threshold
			if (!touched_r && fall > TSF_DATA_W'(thr.touch_th)) begin
				touched_nxt = 1'b1;
			end else if (touched_r && fall < TSF_DATA_W'(thr.release_th)) begin
				touched_nxt = 1'b0;
			end
		end
		if (avg_v) begin
			if (!base_ok_r) begin
				base_nxt = avg_d;
				base_ok_nxt = 1'b1;
			end else if (det_en && (touched_nxt || touch_in)) begin
				run_nxt = 4'd0;
			end else if (mag <= TSF_DATA_W'(max_step_r)) begin
				base_nxt = avg_d;
				run_nxt = 4'd0;
			end else begin
				if (dir_r == up) begin
					run = run_r + 4'd1;
				end
				dir_nxt = up;
				run_nxt = run;
				// step once the run is long enough
				if (run >= tsf_run_limit(drift_count_r)) begin
					run_nxt = 4'd0;
					if (mag <= TSF_DATA_W'(drift_step_r)) begin
						base_nxt = avg_d;
					end else if (up) begin
						base_nxt = base_r + TSF_DATA_W'(drift_step_r);
					end else begin
						base_nxt = base_r - TSF_DATA_W'(drift_step_r);
					end
				end
			end
		end
	end

	// Baseline state
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			base_r <= '0;
			base_ok_r <= 1'b0;
			run_r <= 4'd0;
			dir_r <= 1'b0;
			touched_r <= 1'b0;
		end else begin
			base_r <= base_nxt;
			base_ok_r <= base_ok_nxt;
			run_r <= run_nxt;
			dir_r <= dir_nxt;
			touched_r <= touched_nxt;
		end
	end

	// charge time to the front end
	assign charge_time_sel = cfg_r.charge_time_sel;
	assign charge_cycles = tsf_charge_cycles(cfg_r.charge_time_sel);
	assign reg_rdata = rdata_r;
	assign filt_valid = avg_v;
	assign filt_data = avg_d;
	assign baseline_valid = base_ok_r;
	assign baseline_data = base_r;
	assign touch_active = touched_r;

	default clocking @(posedge clk_sys); endclocking
	default disable iff (reset);

	a_charge_zero_kept: assert property (reg_req.wr &&
		reg_req.addr == TSF_ADDR_FILTER_CFG && reg_req.wdata[7:5] == 3'd0
		|=> $stable(cfg_r.charge_time_sel))
		else $error("charge time took barred code");
	a_cfg_write: assert property (reg_req.wr &&
		reg_req.addr == TSF_ADDR_FILTER_CFG && reg_req.wdata[7:5] != 3'd0
		|=> cfg_r == $past(reg_req.wdata))
		else $error("config write at 0x43 not stored");
	a_max_nonzero: assert property (max_step_r != 6'h00)
		else $error("max step became zero");
	a_drift_nonzero: assert property (drift_step_r != 6'h00)
		else $error("drift step became zero");
	a_fdata_read: assert property (reg_req.rd &&
		reg_req.addr == TSF_ADDR_FDATA_LO && !avg_v
		|=> reg_rdata == $past(avg_d[7:0]))
		else $error("filtered low byte misread");
	a_touch_hold: assert property (touched_r && touched_nxt
		|=> $stable(base_r))
		else $error("baseline moved during touch");
	a_lpf_mode: assert property (!det_en |=> !touched_r)
		else $error("touch seen with detection off");
	a_base_cause: assert property ($past(base_ok_r) && $changed(base_r)
		|-> $past(avg_v))
		else $error("baseline moved without new sample");
	// A limit lowered mid-run is only enforced from the next average on
	a_run_bound: assert property ($past(avg_v) && $stable(drift_count_r)
		|-> run_r < tsf_run_limit(drift_count_r))
		else $error("excursion run passed its limit");
	a_touch_detect: assert property (det_en && avg_v && base_ok_r &&
		!touched_r && base_r > avg_d &&
		base_r - avg_d > TSF_DATA_W'(thr.touch_th) |=> touched_r)
		else $error("large fall did not flag touch");
	a_drift_step: assert property (avg_v && base_ok_r && !det_en &&
		avg_d > base_r + TSF_DATA_W'(max_step_r) + TSF_DATA_W'(drift_step_r)
		&& dir_r && run_r + 4'd1 >= tsf_run_limit(drift_count_r)
		&& base_r < 10'h380
		|=> base_r == $past(base_r) + TSF_DATA_W'($past(drift_step_r)))
		else $error("drift step size wrong");
	a_take_spacing: assert property (take |=> !take [*8])
		else $error("samples taken too close");

	c_touch: cover property (touched_r ##1 !touched_r);
	c_step: cover property (avg_v && run_nxt == 4'd0 && $changed(base_nxt));
	c_read_hi: cover property (reg_req.rd && reg_req.addr == TSF_ADDR_FDATA_HI);
endmodule : tsf_filter

// ---- design/tsf_pkg.sv ----
// Constants, types and helpers for the touch second/third level filter.
// Behaviour
// - Second-stage sample count field 4:3 picks 4, 6, 10 or 18 samples.
// - Sample interval field 2:0 picks 1 ms doubling up to 128 ms.
// - Charge time field 7:5 picks 0.5 us doubling to 32 us; code 0 is barred.
// - The second-stage result is readable as a high and low data byte pair.
// - While a touch is held the baseline keeps its value until release.
// - With all thresholds zero, detection is off and the baseline is a low-pass.
// - Without touch the baseline follows the max, drift step and count settings.
// - Max step 5:0 (1..63) bounds the variation passed; zero is barred.
// - Drift step 5:0 (1..63) is the baseline step on real drift; zero barred.
// - Drift count 3:0 gives the run of excursions needed: 0->1, n->n+1, 15->15.
// - The filter configuration register sits at address 0x43.
// - A touch is seen when baseline minus filtered data passes the threshold.
package tsf_pkg;
	localparam logic [7:0] TSF_ADDR_MAX_STEP = 8'h26;
	localparam logic [7:0] TSF_ADDR_DRIFT_STEP = 8'h27;
	localparam logic [7:0] TSF_ADDR_DRIFT_COUNT = 8'h28;
	localparam logic [7:0] TSF_ADDR_FILTER_CFG = 8'h43;
	localparam logic [7:0] TSF_ADDR_FDATA_LO = 8'h04;
	localparam logic [7:0] TSF_ADDR_FDATA_HI = 8'h05;

	localparam logic [7:0] TSF_CFG_RST = 8'h24;
	localparam logic [5:0] TSF_MAX_STEP_RST = 6'h01;
	localparam logic [5:0] TSF_DRIFT_STEP_RST = 6'h01;
	localparam logic [3:0] TSF_DRIFT_COUNT_RST = 4'h0;

	localparam int TSF_CLK_PERIOD_NS = 10;
	localparam int TSF_BASE_INTERVAL_MS = 1;
	localparam int TSF_MS_CYCLES =
		TSF_BASE_INTERVAL_MS * 1000000 / TSF_CLK_PERIOD_NS;
	localparam int TSF_CHARGE_BASE_NS = 500;
	localparam int TSF_CHARGE_BASE_CYCLES =
		(TSF_CHARGE_BASE_NS + TSF_CLK_PERIOD_NS - 1) / TSF_CLK_PERIOD_NS;

	localparam int TSF_DATA_W = 10;
	localparam int TSF_SUM_W = 15;

	typedef struct packed {
		logic [2:0] charge_time_sel;
		logic [1:0] second_stage_sample_count;
		logic [2:0] sample_interval_sel;
	} tsf_cfg_t;

	typedef struct packed {
		logic [7:0] touch_th;
		logic [7:0] release_th;
	} tsf_thr_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} tsf_reg_req_t;

	// Samples per second-stage average
	function automatic logic [4:0] tsf_sample_n(input logic [1:0] sel);
		unique case (sel)
			2'd0: tsf_sample_n = 5'd4;
			2'd1: tsf_sample_n = 5'd6;
			2'd2: tsf_sample_n = 5'd10;
			2'd3: tsf_sample_n = 5'd18;
		endcase
	endfunction : tsf_sample_n

	// Constant divisors keep each branch a fixed multiplier network
	function automatic logic [9:0] tsf_avg_div(input logic [14:0] s,
		input logic [1:0] sel);
		unique case (sel)
			2'd0: tsf_avg_div = 10'(s / 15'd4);
			2'd1: tsf_avg_div = 10'(s / 15'd6);
			2'd2: tsf_avg_div = 10'(s / 15'd10);
			2'd3: tsf_avg_div = 10'(s / 15'd18);
		endcase
	endfunction : tsf_avg_div

	// Run length needed before drift is believed
	function automatic logic [3:0] tsf_run_limit(input logic [3:0] code);
		tsf_run_limit = (code == 4'hF) ? 4'hF : code + 4'h1;
	endfunction : tsf_run_limit

	// Interval in 1 ms ticks
	function automatic logic [7:0] tsf_interval_ms(input logic [2:0] sel);
		tsf_interval_ms = 8'h01 << sel;
	endfunction : tsf_interval_ms

	// Charge time in clock cycles; code 0 never reaches here
	function automatic logic [11:0] tsf_charge_cycles(input logic [2:0] c);
		tsf_charge_cycles = 12'(TSF_CHARGE_BASE_CYCLES) << (c - 3'd1);
	endfunction : tsf_charge_cycles
endpackage : tsf_pkg
